// file: rtl/nvap_top.sv
// Access protection for program memory, data EEPROM and configuration words.
// Assumes CPU and programmer requests are synchronous single-cycle strobes.
//
// What this block does
// - Block read locks only stop programmer reads/writes, never CPU accesses.
// - Table writes into a block whose write lock is 0 are refused.
// - Table read from inside a cross-read-locked block returns real data.
// - Table read from outside a cross-read-locked block returns zeros.
// - Protection bits go only from 1 to 0 by writes.
// - Only programmer-started chip or block erase sets protection bits.
// - EEPROM read lock blocks programmer reads and writes of EEPROM.
// - EEPROM write lock blocks programmer writes, not reads.
// - CPU EEPROM access ignores both EEPROM locks.
// - Config write lock readable in user mode, writable by programmer only.
// - Device ID table-readable; config words table-readable and writable.
// - ID locations 200000h-200007h reachable by table read and write.
// - ID locations stay readable under code protection.
// - Debugger enable bit at 0 turns the debugger on.
// - Debugger reserves two pins, 2 stack levels, 576 bytes and data addresses EF6h-FFFh.
// - With low-voltage enable set, entry pin is programming only.
// - Low-voltage enable bit resets to 1.
// - High-voltage entry on master clear always works.
// - Low-voltage enable cleared only in high-voltage session.
// - With low-voltage enable 0, the entry pin is ignored.
`timescale 1ns/1ps
`default_nettype none
module nvap_top
	import nvap_pkg::*;
#(
	parameter int NBLK = NVAP_NBLK
) (
	input  wire logic        clk,
	input  wire logic        rstn,
	// AXI4-Lite slave
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// CPU table access
	input  wire logic        table_read_op,
	input  wire logic        table_write_op,
	input  wire logic [21:0] tbl_ptr,
	input  wire logic [21:0] fetch_addr,
	input  wire logic [7:0]  mem_rdata,
	output logic [7:0]       tbl_rdata,
	output logic             tbl_write_en,
	output logic             tbl_denied,
	// External programmer access
	input  wire logic        prog_entry_pin,
	input  wire logic        master_clear_hv,
	input  wire logic        ext_prog_rd,
	input  wire logic        ext_prog_wr,
	input  wire logic        ext_ee_rd,
	input  wire logic        ext_ee_wr,
	input  wire logic [21:0] ext_addr,
	output logic             ext_prog_grant,
	output logic             ext_ee_grant,
	output logic             entry_pin_is_gpio,
	output logic [1:0]       prog_mode,
	output logic             dbg_enable,
	output logic [1:0]       dbg_stack_res,
	output logic             dbg_prog_res,
	output logic             dbg_data_res,
	input  wire logic [11:0] data_addr
);
	if (NBLK < 2 || NBLK > 9) begin : g_bad_nblk
		$error("NBLK must be 2..9");
	end

	logic [8:0]  rd_lock;
	logic [8:0]  wr_lock;
	logic [8:0]  xrd_lock;
	logic [4:0]  misc;
	nvap_mode_e  mode;
	logic        in_prog;
	logic        in_hv;

	// Address to block index; index 15 means outside program blocks
	function automatic logic [3:0] blk_of(input logic [21:0] a);
		logic [21:0] sh;
		sh = a >> NVAP_BLK_SIZE_LOG2;
		if (a > NVAP_PROG_END)
			blk_of = 4'hF;
		else if (a <= NVAP_BOOT_END)
			blk_of = 4'h0;
		else
			blk_of = sh[3:0] + 4'h1;
	endfunction

	logic [3:0] ptr_blk;
	logic [3:0] fet_blk;
	logic       ptr_in;
	logic       is_id;
	logic       is_cfg;
	logic       rd_deny;
	logic       wr_deny;
	always_comb begin
		ptr_blk = blk_of(tbl_ptr);
		fet_blk = blk_of(fetch_addr);
		ptr_in  = (ptr_blk != 4'hF) && (32'(ptr_blk) < NBLK);
		is_id   = (tbl_ptr >= NVAP_ID_BASE) && (tbl_ptr <= NVAP_ID_LAST);
		is_cfg  = (tbl_ptr >= NVAP_CFG_BASE) && (tbl_ptr <= NVAP_CFG_LAST);
		// Block read lock does not enter CPU decisions
		rd_deny = ptr_in && !xrd_lock[ptr_blk] && (ptr_blk != fet_blk);
		wr_deny = (ptr_in && !wr_lock[ptr_blk])
			|| (is_cfg && tbl_ptr != NVAP_DEVID_BASE
				&& tbl_ptr != NVAP_DEVID_BASE + 22'h1
				&& !misc[NVAP_MISC_CFGWR] && !in_prog);
		// ID and config space never read-denied
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			tbl_rdata    <= 8'h00;
			tbl_write_en <= 1'b0;
			tbl_denied   <= 1'b0;
		end else begin
			tbl_rdata    <= (table_read_op && !rd_deny) ? mem_rdata : 8'h00;
			tbl_write_en <= table_write_op && !wr_deny;
			tbl_denied   <= (table_read_op && rd_deny)
				|| (table_write_op && wr_deny);
		end
	end

	// Programming mode entry
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			mode <= NVAP_MODE_USER;
		end else if (master_clear_hv) begin
			mode <= NVAP_MODE_HVPRG;
		end else if (prog_entry_pin && misc[NVAP_MISC_LVP]) begin
			mode <= NVAP_MODE_LVPRG;
		end else begin
			mode <= NVAP_MODE_USER;
		end
	end
	assign in_prog = (mode != NVAP_MODE_USER);
	assign in_hv   = (mode == NVAP_MODE_HVPRG);

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ext_prog_grant    <= 1'b0;
			ext_ee_grant      <= 1'b0;
			entry_pin_is_gpio <= 1'b0;
			prog_mode         <= 2'h0;
			dbg_enable        <= 1'b0;
			dbg_stack_res     <= 2'h0;
			dbg_prog_res      <= 1'b0;
			dbg_data_res      <= 1'b0;
		end else begin
			ext_prog_grant <= in_prog && (ext_prog_rd || ext_prog_wr)
				&& !(blk_of(ext_addr) != 4'hF
				&& !rd_lock[blk_of(ext_addr)]);
			// CPU EEPROM path never passes through here
			ext_ee_grant <= in_prog
				&& ((ext_ee_rd && misc[NVAP_MISC_EERD])
				|| (ext_ee_wr && misc[NVAP_MISC_EERD]
				&& misc[NVAP_MISC_EEWR]));
			entry_pin_is_gpio <= !misc[NVAP_MISC_LVP];
			prog_mode      <= mode;
			dbg_enable     <= !misc[NVAP_MISC_DBG];
			dbg_stack_res  <= misc[NVAP_MISC_DBG] ? 2'h0 : NVAP_DBG_STACK;
			dbg_prog_res   <= !misc[NVAP_MISC_DBG]
				&& (tbl_ptr > NVAP_PROG_END - NVAP_DBG_PROG_RES)
				&& (tbl_ptr <= NVAP_PROG_END);
			dbg_data_res   <= !misc[NVAP_MISC_DBG]
				&& (data_addr > NVAP_DATA_END - NVAP_DBG_DATA_RES);
		end
	end

	// AXI4-Lite write path
	logic        aw_held;
	logic        w_held;
	logic [7:0]  aw_q;
	logic [31:0] w_q;
	logic [3:0]  ws_q;
	logic        do_wr;
	assign do_wr = aw_held && w_held && !s_axi_bvalid;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			aw_held       <= 1'b0;
			w_held        <= 1'b0;
			aw_q          <= 8'h00;
			w_q           <= 32'h0000_0000;
			ws_q          <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
		end else begin
			s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
			s_axi_wready  <= !w_held && !s_axi_wready && s_axi_wvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				aw_q    <= s_axi_awaddr;
			end else if (do_wr) begin
				aw_held <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				w_q    <= s_axi_wdata;
				// Strobes may change once wvalid drops, so keep them
				ws_q   <= s_axi_wstrb;
			end else if (do_wr) begin
				w_held <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= NVAP_RESP_OKAY;
		end else if (do_wr) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= (aw_q[7:2] > NVAP_REG_ERASE[7:2])
				? NVAP_RESP_SLVERR : NVAP_RESP_OKAY;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// Protection storage; writes only clear, erase only from programmer
	logic erase_ok;
	assign erase_ok = do_wr && in_prog && (aw_q[7:2] == NVAP_REG_ERASE[7:2])
		&& ws_q[0];
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rd_lock  <= NVAP_LOCK_RESET;
			wr_lock  <= NVAP_LOCK_RESET;
			xrd_lock <= NVAP_LOCK_RESET;
			misc     <= NVAP_MISC_RESET;
		end else if (erase_ok && w_q[9]) begin
			// Chip erase restores all lock registers and misc bits 0-2; debug and LVP bits keep their value
			rd_lock  <= NVAP_LOCK_RESET;
			wr_lock  <= NVAP_LOCK_RESET;
			xrd_lock <= NVAP_LOCK_RESET;
			misc     <= misc | 5'h07;
		end else if (erase_ok) begin
			rd_lock  <= rd_lock | w_q[8:0];
			wr_lock  <= wr_lock | w_q[8:0];
			xrd_lock <= xrd_lock | w_q[8:0];
		end else if (do_wr && ws_q[0]) begin
			case (aw_q)
				NVAP_REG_RDLOCK: rd_lock  <= rd_lock & w_q[8:0];
				NVAP_REG_WRLOCK: wr_lock  <= wr_lock & w_q[8:0];
				NVAP_REG_XRLOCK: xrd_lock <= xrd_lock & w_q[8:0];
				NVAP_REG_MISC: begin
					misc[1:0] <= misc[1:0] & w_q[1:0];
					misc[3]   <= misc[3] & w_q[3];
					if (in_prog)
						misc[2] <= misc[2] & w_q[2];
					if (in_hv)
						misc[4] <= misc[4] & w_q[4];
				end
				default: ;
			endcase
		end
	end

	// AXI4-Lite read path
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= NVAP_RESP_OKAY;
		end else begin
			s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= NVAP_RESP_OKAY;
				case (s_axi_araddr)
					NVAP_REG_RDLOCK: s_axi_rdata <= {23'h0, rd_lock};
					NVAP_REG_WRLOCK: s_axi_rdata <= {23'h0, wr_lock};
					NVAP_REG_XRLOCK: s_axi_rdata <= {23'h0, xrd_lock};
					NVAP_REG_MISC:   s_axi_rdata <= {27'h0, misc};
					NVAP_REG_STATUS: s_axi_rdata <= {30'h0, mode};
					NVAP_REG_ERASE:  s_axi_rdata <= 32'h0000_0000;
					default: begin
						s_axi_rdata <= 32'h0000_0000;
						s_axi_rresp <= NVAP_RESP_SLVERR;
					end
				endcase
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end
endmodule
`default_nettype wire

// file: shared/nvap_pkg.sv
// Constants for the nonvolatile access protection block.
// Assumes byte-addressed 22-bit table space and AXI4-Lite register access.
package nvap_pkg;
	localparam int          NVAP_ADDR_W        = 22;
	localparam int          NVAP_NBLK          = 9;
	// Block map: boot block index 0, then user blocks
	localparam logic [21:0] NVAP_BOOT_END      = 22'h0001FF;
	localparam logic [21:0] NVAP_BLK_SIZE_LOG2 = 22'h00000E;
	localparam logic [21:0] NVAP_PROG_END      = 22'h01FFFF;
	// ID and config space sit above bit 20, so the pointer needs 22 bits
	localparam logic [21:0] NVAP_ID_BASE       = 22'h200000;
	localparam logic [21:0] NVAP_ID_LAST       = 22'h200007;
	localparam logic [21:0] NVAP_CFG_BASE      = 22'h300000;
	localparam logic [21:0] NVAP_CFG_LAST      = 22'h3FFFFF;
	localparam logic [21:0] NVAP_DEVID_BASE    = 22'h3FFFFE;
	// Debugger reservations
	localparam logic [21:0] NVAP_DBG_PROG_RES  = 22'h000240;
	localparam logic [11:0] NVAP_DBG_DATA_RES  = 12'h00A;
	localparam logic [11:0] NVAP_DATA_END      = 12'hEFF;
	localparam logic [1:0]  NVAP_DBG_STACK     = 2'h2;
	// Register offsets
	localparam logic [7:0]  NVAP_REG_RDLOCK    = 8'h00;
	localparam logic [7:0]  NVAP_REG_WRLOCK    = 8'h04;
	localparam logic [7:0]  NVAP_REG_XRLOCK    = 8'h08;
	localparam logic [7:0]  NVAP_REG_MISC      = 8'h0C;
	localparam logic [7:0]  NVAP_REG_STATUS    = 8'h10;
	localparam logic [7:0]  NVAP_REG_ERASE     = 8'h14;
	// Misc register bit positions
	localparam int          NVAP_MISC_EERD     = 0;
	localparam int          NVAP_MISC_EEWR     = 1;
	localparam int          NVAP_MISC_CFGWR    = 2;
	localparam int          NVAP_MISC_DBG      = 3;
	localparam int          NVAP_MISC_LVP      = 4;
	// Erased (factory) state is all ones
	localparam logic [8:0]  NVAP_LOCK_RESET    = 9'h1FF;
	localparam logic [4:0]  NVAP_MISC_RESET    = 5'h1F;
	localparam logic [1:0]  NVAP_RESP_OKAY     = 2'h0;
	localparam logic [1:0]  NVAP_RESP_SLVERR   = 2'h2;
	typedef enum logic [1:0] {
		NVAP_MODE_USER  = 2'b00,
		NVAP_MODE_LVPRG = 2'b01,
		NVAP_MODE_HVPRG = 2'b10
	} nvap_mode_e;
endpackage

// file: testbench/nvap_props.sv
// Concurrent checks on the table-access and mode ports of nvap_top.
// Assumes one clock domain with rstn asynchronous and active low.
`timescale 1ns/1ps
`default_nettype none
module nvap_props
	import nvap_pkg::*;
(
	input wire logic        clk,
	input wire logic        rstn,
	input wire logic        table_read_op,
	input wire logic        table_write_op,
	input wire logic [21:0] tbl_ptr,
	input wire logic [21:0] fetch_addr,
	input wire logic [7:0]  mem_rdata,
	input wire logic [7:0]  tbl_rdata,
	input wire logic        tbl_write_en,
	input wire logic        tbl_denied,
	input wire logic        master_clear_hv,
	input wire logic        entry_pin_is_gpio,
	input wire logic [1:0]  prog_mode,
	input wire logic        dbg_enable,
	input wire logic [1:0]  dbg_stack_res
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	sequence s_rd;
		table_read_op && !table_write_op;
	endsequence
	// Boot block shares high bits with the first user block
	sequence s_same;
		tbl_ptr[21:14] == fetch_addr[21:14] && tbl_ptr > NVAP_BOOT_END
			&& fetch_addr > NVAP_BOOT_END;
	endsequence
	property p_wr_cause;
		tbl_write_en |-> $past(table_write_op);
	endproperty
	property p_wr_excl;
		table_write_op && !table_read_op |=> tbl_write_en != tbl_denied;
	endproperty
	property p_deny_zero;
		s_rd ##1 tbl_denied |-> tbl_rdata == 8'h00;
	endproperty
	property p_pass;
		s_rd ##1 !tbl_denied |-> tbl_rdata == $past(mem_rdata);
	endproperty
	property p_same_blk;
		s_rd ##0 s_same |=> !tbl_denied;
	endproperty
	property p_id_rd;
		s_rd ##0 (tbl_ptr >= NVAP_ID_BASE && tbl_ptr <= NVAP_ID_LAST)
			|=> !tbl_denied;
	endproperty
	property p_hv;
		// Mode register, then its registered copy: two edges
		master_clear_hv |-> ##2 prog_mode == NVAP_MODE_HVPRG;
	endproperty
	property p_gpio;
		entry_pin_is_gpio |-> prog_mode != NVAP_MODE_LVPRG;
	endproperty
	property p_dbg;
		dbg_stack_res == (dbg_enable ? NVAP_DBG_STACK : 2'h0);
	endproperty
	a_wr_cause: assert property (p_wr_cause)
		else $error("write enable without request");
	a_wr_excl: assert property (p_wr_excl)
		else $error("write neither granted nor refused");
	a_deny_zero: assert property (p_deny_zero)
		else $error("denied read returned data");
	a_pass: assert property (p_pass)
		else $error("allowed read data wrong");
	a_same_blk: assert property (p_same_blk)
		else $error("read from own block denied");
	a_id_rd: assert property (p_id_rd)
		else $error("id location read denied");
	a_hv: assert property (p_hv)
		else $error("high voltage entry missed");
	a_gpio: assert property (p_gpio)
		else $error("entry pin honoured while disabled");
	a_dbg: assert property (p_dbg)
		else $error("debug stack reservation wrong");
endmodule
bind nvap_top nvap_props chk_u (.clk, .rstn, .table_read_op, .table_write_op,
	.tbl_ptr, .fetch_addr, .mem_rdata, .tbl_rdata, .tbl_write_en, .tbl_denied,
	.master_clear_hv, .entry_pin_is_gpio, .prog_mode, .dbg_enable,
	.dbg_stack_res);
`default_nettype wire

// file: testbench/nvap_prog_model.sv
// Programmer model: entry pins and one-cycle external access strobes.
// Assumes the bench calls its tasks right after a rising edge.
`timescale 1ns/1ps
`default_nettype none
module nvap_prog_model (
	input  wire logic   clk,
	output logic        prog_entry_pin,
	output logic        master_clear_hv,
	output logic        ext_prog_rd,
	output logic        ext_prog_wr,
	output logic        ext_ee_rd,
	output logic        ext_ee_wr,
	output logic [21:0] ext_addr
);
	initial begin
		{prog_entry_pin, master_clear_hv} = 2'h0;
		{ext_prog_rd, ext_prog_wr, ext_ee_rd, ext_ee_wr} = 4'h0;
		ext_addr = 22'h000000;
	end
	// Pin high asks for low-voltage entry
	task pins(input logic pin, input logic hv);
		@(posedge clk);
		prog_entry_pin <= pin;
		master_clear_hv <= hv;
		repeat (2) @(posedge clk);
	endtask
	// Address is scrambled once released so stale values never pass
	task req(input logic [3:0] k, input logic [21:0] a);
		@(posedge clk);
		{ext_prog_rd, ext_prog_wr, ext_ee_rd, ext_ee_wr} <= k;
		ext_addr <= a;
		@(posedge clk);
		{ext_prog_rd, ext_prog_wr, ext_ee_rd, ext_ee_wr} <= 4'h0;
		ext_addr <= ~a;
		#1;
	endtask
endmodule
`default_nettype wire

// file: testbench/nonvolatile_access_protection_bench.sv
// Self-checking bench for nvap_top against a small lock model.
// Assumes the AXI and table timing of the designer's notes.
`timescale 1ns/1ps
`default_nettype none
module nonvolatile_access_protection_bench;
	import nvap_pkg::*;
	logic clk, rstn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic s_axi_rvalid, s_axi_rready, table_read_op, table_write_op;
	logic tbl_write_en, tbl_denied, prog_entry_pin, master_clear_hv;
	logic ext_prog_rd, ext_prog_wr, ext_ee_rd, ext_ee_wr, ext_prog_grant;
	logic ext_ee_grant, entry_pin_is_gpio, dbg_enable, dbg_prog_res;
	logic dbg_data_res;
	logic [7:0]  s_axi_awaddr, s_axi_araddr, mem_rdata, tbl_rdata;
	logic [31:0] s_axi_wdata, s_axi_rdata, seed;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, prog_mode, dbg_stack_res;
	logic [21:0] tbl_ptr, fetch_addr, ext_addr;
	logic [11:0] data_addr;
	int          rl, wl, xl, misc, mode, bad_count, cmp_count;
	nvap_top dut_u (.clk, .rstn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.table_read_op, .table_write_op, .tbl_ptr, .fetch_addr, .mem_rdata,
		.tbl_rdata, .tbl_write_en, .tbl_denied, .prog_entry_pin, .master_clear_hv,
		.ext_prog_rd, .ext_prog_wr, .ext_ee_rd, .ext_ee_wr, .ext_addr,
		.ext_prog_grant, .ext_ee_grant, .entry_pin_is_gpio, .prog_mode,
		.dbg_enable, .dbg_stack_res, .dbg_prog_res, .dbg_data_res, .data_addr);
	nvap_prog_model prog_u (.clk, .prog_entry_pin, .master_clear_hv,
		.ext_prog_rd, .ext_prog_wr, .ext_ee_rd, .ext_ee_wr, .ext_addr);
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic logic [21:0] ba(input int i);
		return (i == 0) ? 22'h000100 : 22'((i - 1) << 14) + 22'h001000;
	endfunction
	function automatic logic [31:0] ex(input logic [7:0] a);
		case (a)
			8'h00: return rl;
			8'h04: return wl;
			8'h08: return xl;
			8'h0C: return misc;
			8'h10: return mode;
			default: return 32'h00000000;
		endcase
	endfunction
	task chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task test_done;
		$display("compares=%0d mismatches=%0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task axw(input logic [7:0] a, input logic [31:0] d);
		bit ad, wd;
		{ad, wd} = 2'b00;
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
		while (!(ad && wd)) begin
			@(posedge clk);
			if (s_axi_awready) begin ad = 1; s_axi_awvalid <= 1'b0; end
			if (s_axi_wready) begin wd = 1; s_axi_wvalid <= 1'b0; end
		end
		do @(posedge clk); while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
		chk(s_axi_bresp, a > 8'h14 ? NVAP_RESP_SLVERR : NVAP_RESP_OKAY);
	endtask
	task axr(input logic [7:0] a);
		@(posedge clk);
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'b11;
		do @(posedge clk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		while (!s_axi_rvalid) @(posedge clk);
		s_axi_rready <= 1'b0;
		chk(s_axi_rresp, a > 8'h14 ? NVAP_RESP_SLVERR : NVAP_RESP_OKAY);
		chk(s_axi_rdata, ex(a));
	endtask
	task tb(input logic w, input logic [21:0] p, f, input logic ok);
		logic [7:0] m;
		logic [11:0] d;
		m = 8'(rnd());
		d = 12'(rnd());
		@(posedge clk);
		{table_write_op, table_read_op} <= {w, !w};
		{tbl_ptr, fetch_addr, mem_rdata} <= {p, f, m};
		data_addr <= d;
		@(posedge clk);
		{table_write_op, table_read_op} <= 2'b00;
		#1;
		chk(tbl_denied, !ok);
		if (w) chk(tbl_write_en, ok);
		else chk(tbl_rdata, ok ? m : 8'h00);
		chk(dbg_data_res, !misc[3] && d > 12'hEF5);
	endtask
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		#100000;
		bad_count++;
		test_done;
	end
	initial begin
		{rstn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
		{s_axi_arvalid, s_axi_rready, table_read_op, table_write_op} = 4'h0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 52'hF;
		{tbl_ptr, fetch_addr, mem_rdata, data_addr} = 64'h0;
		{seed, bad_count, cmp_count} = {32'h7E8B574A, 64'h0};
		{rl, wl, xl, misc, mode} = {32'h1FF, 32'h1FF, 32'h1FF, 32'h1F, 32'h0};
		repeat (5) @(posedge clk);
		rstn <= 1'b1;
		for (int a = 0; a <= 16; a += 4) axr(8'(a));
		axr(8'h20);
		$display("test reset done");
		axw(8'h0C, 32'h3);
		misc = 'h17;
		axr(8'h0C);
		chk(dbg_stack_res, NVAP_DBG_STACK);
		chk(dbg_enable, 1);
		wl = rnd() & 'h1FF;
		xl = rnd() & 'h1FF;
		rl = 0;
		axw(8'h00, 32'h0);
		axw(8'h04, wl);
		axw(8'h08, xl);
		axw(8'h04, 32'h1FF);
		axw(8'h14, 32'h3FF);
		for (int a = 0; a <= 8; a += 4) axr(8'(a));
		for (int i = 0; i < 9; i++) begin
			tb(1, ba(i), ba(i), wl[i]);
			tb(0, ba(i), ba((i + 1) % 9), xl[i]);
			tb(0, ba(i), ba(i) + 21'h4, 1);
		end
		tb(0, NVAP_ID_BASE, ba(2), 1);
		tb(1, NVAP_ID_LAST, ba(2), 1);
		tb(1, NVAP_CFG_BASE, ba(2), 1);
		tb(0, NVAP_DEVID_BASE, ba(2), 1);
		tb(0, 22'h01FFF0, 22'h01FFF0, 1);
		chk(dbg_prog_res, 1);
		$display("test table done");
		prog_u.pins(1, 0);
		mode = 1;
		axr(8'h10);
		chk(prog_mode, mode);
		chk(entry_pin_is_gpio, 0);
		prog_u.pins(0, 1);
		mode = 2;
		axr(8'h10);
		chk(prog_mode, mode);
		prog_u.req(4'h8, ba(3));
		chk(ext_prog_grant, 0);
		axw(8'h14, 32'h1FF);
		{rl, wl, xl} = {32'h1FF, 32'h1FF, 32'h1FF};
		for (int a = 0; a <= 8; a += 4) axr(8'(a));
		prog_u.req(4'h8, ba(3));
		chk(ext_prog_grant, 1);
		prog_u.req(4'h2, 22'h0);
		chk(ext_ee_grant, 1);
		axw(8'h0C, 32'hFFFFFFFD);
		misc = 'h15;
		axr(8'h0C);
		prog_u.req(4'h1, 22'h0);
		chk(ext_ee_grant, 0);
		prog_u.req(4'h2, 22'h0);
		chk(ext_ee_grant, 1);
		axw(8'h0C, 32'h0);
		misc = 0;
		axr(8'h0C);
		prog_u.req(4'h2, 22'h0);
		chk(ext_ee_grant, 0);
		axw(8'h14, 32'h200);
		misc = 7;
		axr(8'h0C);
		prog_u.pins(1, 0);
		mode = 0;
		axr(8'h10);
		chk(entry_pin_is_gpio, 1);
		$display("test programmer done");
		test_done;
	end
endmodule
`default_nettype wire
